/* pkg/adc_flag_pkg.sv */
package adc_flag_pkg;
   localparam int NCH = 8;
   localparam int CH_W = 3;
   localparam int DW = 10;
   localparam int AW = 8;
   ////////////////////////////////////////////////////////////////////////////
   // Register offsets
   localparam logic [AW-1:0] OFS_CTRL = 8'h00;
   localparam logic [AW-1:0] OFS_MODE = 8'h04;
   localparam logic [AW-1:0] OFS_CHEN = 8'h10;
   localparam logic [AW-1:0] OFS_CHDIS = 8'h14;
   localparam logic [AW-1:0] OFS_CHSR = 8'h18;
   localparam logic [AW-1:0] OFS_SR = 8'h1c;
   localparam logic [AW-1:0] OFS_LAST_RES = 8'h20;
   localparam logic [AW-1:0] OFS_EVT = 8'h24;
   localparam logic [AW-1:0] OFS_MASK = 8'h28;
   localparam logic [AW-1:0] OFS_CH_RES0 = 8'h40;
   ////////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int CTRL_START = 0;
   localparam int MODE_SLEEP = 0;
   localparam int SR_OVR_LSB = 8;
   localparam int SR_RES_RDY = 16;
   localparam int SR_ALL_OVR = 17;
   localparam int LAST_RES_CH_LSB = 12;
   localparam int EVT_EOC = 0;
   localparam int EVT_RES_RDY = 1;
   localparam int EVT_OVR = 2;
   localparam int EVT_W = 3;
   ////////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [NCH-1:0] CHEN_RST = 8'h00;
   localparam logic MODE_RST = 1'b0;
   localparam logic [EVT_W-1:0] MASK_RST = 3'h0;
   ////////////////////////////////////////////////////////////////////////////
   // Timing
   localparam int CLK_NS = 10;
   localparam int CONV_NS = 200;
   localparam int CONV_CYC = (CONV_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [7:0] CONV_CNT = 8'(CONV_CYC - 1);
   ////////////////////////////////////////////////////////////////////////////
   // Types
   typedef struct packed {
      logic valid;
      logic [CH_W-1:0] ch;
      logic [DW-1:0] data;
   } eoc_t;
   typedef enum logic [0:0] {SEQ_IDLE, SEQ_CONV} seq_state_t;
   typedef struct packed {
      seq_state_t state;
      logic [CH_W-1:0] ch;
      logic [7:0] cnt;
      logic sleeping;
      eoc_t eoc;
      logic [DW-1:0] sync1;
      logic [DW-1:0] sync2;
   } seq_st_t;
   typedef struct packed {
      logic [NCH-1:0][DW-1:0] ch_res;
      logic [DW-1:0] last_res;
      logic [CH_W-1:0] last_ch;
      logic [NCH-1:0] done;
      logic [NCH-1:0] ovr;
      logic [NCH-1:0] chen;
      logic res_rdy;
      logic all_ovr;
      logic sleep_mode;
      logic [EVT_W-1:0] evt;
      logic [EVT_W-1:0] mask;
      logic irq;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } flag_st_t;
endpackage : adc_flag_pkg

/* rtl/adc_conv_seq.sv */
`timescale 1ns/1ps
module adc_conv_seq
   import adc_flag_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Control from the flag logic
   input wire logic start,
   input wire logic [NCH-1:0] chen,
   input wire logic sleep_mode,
   // Converter result pins
   input wire logic [DW-1:0] sample,
   // Results
   output eoc_t eoc,
   output logic sleeping
);
   seq_st_t q;
   seq_st_t s;
   logic [CH_W:0] nx;

   // Lowest enabled channel at or above from
   function automatic logic [CH_W:0] next_en(input logic [NCH-1:0] en,
                                             input logic [CH_W:0] from);
      logic [CH_W:0] r;
      r = '0;
      for (int i = NCH - 1; i >= 0; i--) begin
         if (i >= int'(from) && en[i]) begin
            r = {1'b1, CH_W'(i)};
         end
      end
      return r;
   endfunction : next_en

   always_comb begin
      s = q;
      nx = '0;
      s.eoc.valid = 1'b0;
      s.sync1 = sample;
      s.sync2 = q.sync1;
      case (q.state)
         SEQ_IDLE: begin
            if (start) begin
               s.sleeping = 1'b0;
               nx = next_en(chen, '0);
               if (nx[CH_W]) begin
                  s.state = SEQ_CONV;
                  s.ch = nx[CH_W-1:0];
                  s.cnt = CONV_CNT;
               end
            end
         end
         SEQ_CONV: begin
            if (q.cnt == 8'h00) begin
               // Channel enable is not re-checked here: a disable lands mid-way
               s.eoc = {1'b1, q.ch, q.sync2};
               nx = next_en(chen, {1'b0, q.ch} + 1'b1);
               if (nx[CH_W]) begin
                  s.ch = nx[CH_W-1:0];
                  s.cnt = CONV_CNT;
               end else begin
                  s.state = SEQ_IDLE;
                  // Sleep only ever entered on a finished sequence
                  s.sleeping = sleep_mode; // R15
               end
            end else begin
               s.cnt = q.cnt - 8'h01;
            end
         end
         default: s.state = SEQ_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
      end else begin
         q <= s;
      end
   end

   assign eoc = q.eoc;
   assign sleeping = q.sleeping;
endmodule : adc_conv_seq

/* rtl/adc_status_flag_logic.sv */
`timescale 1ns/1ps
// How it works
// R1: Any per-channel result read clears data-ready, as does a last-result read.
// R2: End of conversion stores channel and last result, sets that channel's done flag.
// R3: Last-result read during end of conversion keeps a set data-ready set.
// R4: Result read during end on enabled channel with done set skips data-ready.
// R5: Disable write during end of conversion stores data but does not raise data-ready.
// R6: Status read during end of conversion leaves global overrun unchanged.
// R7: Status read clears global overrun when no end of conversion coincides with it.
// R8: End of conversion with data-ready set raises global overrun.
// R9: Result read during end, done and ready set, foreign last result: no global overrun.
// R10: Disable during end with done and ready set: channel overrun only.
// R11: Own or last-result read clears done; status read clears channel overrun.
// R12: Status read coinciding with done set of channel i keeps its overrun.
// R13: Disabled channel may still flag done when a result read meets its end.
// R14: Read of third channel during end of y clears done of previous x instead.
// R15: Sleep request while idle takes effect only after a conversion completes.
// R16: Software sets sleep, then writes start, to sleep after that conversion.
// R17: Software ignores done flags of channels it has disabled.
// R18: Software avoids data-ready when it also reads per-channel results.
module adc_status_flag_logic
   import adc_flag_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Converter result pins
   input wire logic [DW-1:0] sample,
   // Status outputs
   output logic irq,
   output logic sleeping
);
   flag_st_t q;
   flag_st_t s;
   eoc_t e;
   logic acc;
   logic rd;
   logic wr;
   logic rd_sr;
   logic rd_last;
   logic rd_chres;
   logic dis_wr;
   logic start;
   logic hit;
   logic [CH_W-1:0] x;
   logic [CH_W-1:0] res_ch;
   logic [31:0] rdv;
   logic ok;
   logic r9;
   logic r10;

   ////////////////////////////////////////////////////////////////////////////
   // Bus decode
   assign acc = psel && penable && q.pready;
   assign rd = acc && !pwrite;
   assign wr = acc && pwrite;
   assign rd_sr = rd && paddr == OFS_SR;
   assign rd_last = rd && paddr == OFS_LAST_RES;
   // Decoded from the window alone, so every result read takes part in the races
   assign rd_chres = rd && paddr[AW-1:5] == OFS_CH_RES0[AW-1:5];
   assign res_ch = paddr[4:2];
   assign dis_wr = wr && paddr == OFS_CHDIS && |pwdata[NCH-1:0];
   assign start = wr && paddr == OFS_CTRL && pwdata[CTRL_START];
   assign x = e.ch;
   // A result read meeting the end lets a disabled channel through
   assign hit = e.valid && (q.chen[x] || rd_chres); // R13

   adc_conv_seq u_seq (
      .pclk(pclk),
      .presetn(presetn),
      .start(start),
      .chen(q.chen),
      .sleep_mode(q.sleep_mode), // R16
      .sample(sample),
      .eoc(e),
      .sleeping(sleeping)
   );

   always_comb begin
      s = q;
      rdv = 32'h0;
      ok = 1'b1;
      r9 = 1'b0;
      r10 = 1'b0;
      s.pready = 1'b0;
      s.pslverr = 1'b0;
      /////////////////////////////////////////////////////////////////////////
      // Setup phase: data is sampled one edge ahead of the access edge
      case (paddr)
         OFS_CTRL, OFS_CHEN, OFS_CHDIS: rdv = 32'h0;
         OFS_MODE: rdv[MODE_SLEEP] = q.sleep_mode;
         OFS_CHSR: rdv[NCH-1:0] = q.chen;
         OFS_SR: begin
            rdv[NCH-1:0] = q.done;
            rdv[SR_OVR_LSB +: NCH] = q.ovr;
            rdv[SR_RES_RDY] = q.res_rdy;
            rdv[SR_ALL_OVR] = q.all_ovr;
         end
         OFS_LAST_RES: begin
            rdv[DW-1:0] = q.last_res;
            rdv[LAST_RES_CH_LSB +: CH_W] = q.last_ch;
         end
         OFS_EVT: rdv[EVT_W-1:0] = q.evt;
         OFS_MASK: rdv[EVT_W-1:0] = q.mask;
         default: begin
            if (paddr[AW-1:5] == OFS_CH_RES0[AW-1:5] && paddr[1:0] == 2'h0) begin
               rdv[DW-1:0] = q.ch_res[paddr[4:2]];
            end else begin
               ok = 1'b0;
            end
         end
      endcase
      if (psel && !penable) begin
         s.pready = 1'b1;
         s.pslverr = !ok;
         if (!pwrite) begin
            s.prdata = rdv;
         end
      end
      /////////////////////////////////////////////////////////////////////////
      // Register writes on the access edge
      if (wr) begin
         case (paddr)
            OFS_MODE: s.sleep_mode = pwdata[MODE_SLEEP];
            OFS_CHEN: s.chen = q.chen | pwdata[NCH-1:0];
            OFS_CHDIS: s.chen = q.chen & ~pwdata[NCH-1:0];
            OFS_MASK: s.mask = pwdata[EVT_W-1:0];
            OFS_EVT: s.evt = q.evt & ~pwdata[EVT_W-1:0];
            default: s.mask = q.mask;
         endcase
      end
      /////////////////////////////////////////////////////////////////////////
      // Done clears by result reads
      if (rd_last) begin
         s.done[q.last_ch] = 1'b0; // R11
      end
      if (rd_chres) begin
         if (e.valid && res_ch != x && res_ch != q.last_ch && q.chen[res_ch]) begin
            // Clear is steered by the previous conversion, not the address
            // Software polling done bits may see a stale flag here
            s.done[q.last_ch] = 1'b0; // R14
         end else begin
            s.done[res_ch] = 1'b0; // R11
         end
      end
      // Overrun clear on status read, except the channel being set now
      if (rd_sr) begin
         s.ovr = q.ovr & (hit ? (NCH'(1) << x) : '0); // R11 R12
      end
      /////////////////////////////////////////////////////////////////////////
      // End of conversion; sets come after clears so they win
      if (hit) begin
         s.ch_res[x] = e.data; // R2 R5
         s.last_res = e.data;
         s.last_ch = x;
         s.done[x] = 1'b1; // R2
         if (q.done[x]) begin
            s.ovr[x] = 1'b1; // R10
         end
      end
      /////////////////////////////////////////////////////////////////////////
      // Data-ready
      if (rd_last || rd_chres) begin
         s.res_rdy = 1'b0; // R1
      end
      // Read beats set here, so a result can arrive with no ready flag
      if (hit && !dis_wr && !(rd_chres && q.done[x] && q.chen[x])) begin
         s.res_rdy = 1'b1; // R4 R5
      end
      // Kept even for a disabled channel: no new data behind it
      if (rd_last && e.valid && q.res_rdy) begin
         s.res_rdy = 1'b1; // R3
      end
      /////////////////////////////////////////////////////////////////////////
      // Global overrun
      r9 = rd_chres && q.done[x] && !q.all_ovr && q.last_ch != x && q.last_ch != res_ch; // R9
      r10 = dis_wr && q.done[x]; // R10
      // Frozen on a status race: an overrun can be lost there
      if (!(rd_sr && e.valid)) begin // R6
         if (rd_sr) begin
            s.all_ovr = 1'b0; // R7
         end
         if (hit && q.res_rdy && !r9 && !r10) begin
            s.all_ovr = 1'b1; // R8
         end
      end
      /////////////////////////////////////////////////////////////////////////
      // Sticky events, write one to clear, a set in the same cycle wins
      if (hit) begin
         s.evt[EVT_EOC] = 1'b1;
      end
      if (s.res_rdy && !q.res_rdy) begin
         s.evt[EVT_RES_RDY] = 1'b1;
      end
      if ((s.all_ovr && !q.all_ovr) || |(s.ovr & ~q.ovr)) begin
         s.evt[EVT_OVR] = 1'b1;
      end
      s.irq = |(s.evt & s.mask);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
         q.chen <= CHEN_RST;
         q.sleep_mode <= MODE_RST;
         q.mask <= MASK_RST;
      end else begin
         q <= s;
      end
   end

   assign prdata = q.prdata;
   assign pready = q.pready;
   assign pslverr = q.pslverr;
   assign irq = q.irq;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   chk_rdy_chres_clr: assert property (rd_chres && !e.valid |=> !q.res_rdy) // R1
      else $error("data-ready not cleared by result read");
   chk_store_last: assert property (hit |=> q.last_res == $past(e.data) && q.done[$past(x)]) // R2
      else $error("end of conversion not stored");
   chk_rdy_keep: assert property (rd_last && e.valid && q.res_rdy |=> q.res_rdy) // R3
      else $error("data-ready lost on last-result race");
   chk_rdy_skip: assert property (rd_chres && e.valid && q.chen[x] && q.done[x]
                                  |=> !q.res_rdy) // R4
      else $error("data-ready set despite result read race");
   chk_rdy_dis: assert property (dis_wr && e.valid && !q.res_rdy |=> !q.res_rdy) // R5
      else $error("data-ready raised during disable");
   chk_allovr_hold: assert property (rd_sr && e.valid |=> $stable(q.all_ovr)) // R6
      else $error("global overrun changed on status race");
   chk_allovr_clr: assert property (rd_sr && !e.valid |=> !q.all_ovr) // R7
      else $error("global overrun not cleared");
   chk_allovr_set: assert property (hit && q.res_rdy && !rd_sr && !rd_chres && !dis_wr
                                    |=> q.all_ovr) // R8
      else $error("global overrun not set");
   chk_allovr_chres: assert property (hit && rd_chres && q.chen[x] && q.done[x] && q.res_rdy
                                      && !q.all_ovr && q.last_ch != x && q.last_ch != res_ch
                                      |=> !q.all_ovr) // R9
      else $error("global overrun set on result read race");
   chk_ovr_dis: assert property (dis_wr && hit && q.done[x] && q.res_rdy && !q.all_ovr
                                 |=> !q.all_ovr && q.ovr[$past(x)]) // R10
      else $error("disable race overrun mismatch");
   chk_done_clr: assert property (rd_last && !e.valid |=> !q.done[$past(q.last_ch)]) // R11
      else $error("done not cleared by last-result read");
   chk_ovr_keep: assert property (rd_sr && hit && q.ovr[x] |=> q.ovr[$past(x)]) // R12
      else $error("overrun cleared during done set");
   chk_done_dis: assert property (e.valid && !q.chen[x] && rd_chres
                                  |=> q.done[$past(x)]) // R13
      else $error("disabled channel done not raised");
   chk_done_swap: assert property (rd_chres && e.valid && res_ch != x && res_ch != q.last_ch
                                   && q.last_ch != x && q.chen[res_ch]
                                   |=> !q.done[$past(q.last_ch)]) // R14
      else $error("previous done not cleared on third-channel read");
   chk_sleep_entry: assert property ($rose(sleeping) |-> e.valid) // R15
      else $error("sleep entered without a finished conversion");
endmodule : adc_status_flag_logic

/* tb/adc_status_flag_logic_tb.sv */
`timescale 1ns/1ps
module adc_status_flag_logic_tb;
   import adc_flag_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, sleeping, err;
   logic [AW-1:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [DW-1:0] sample, d;
   logic [CH_W-1:0] c;
   int errors, checks, cyc;

   adc_status_flag_logic DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sample(sample), .irq(irq), .sleeping(sleeping));

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   // Hang guard: whole run needs well under this
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         errors++;
         end_sim();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] exp_sr(logic [7:0] dn, logic [7:0] ov, logic dr, logic gv);
      return {14'h0, gv, dr, ov, dn};
   endfunction : exp_sr

   function automatic logic [31:0] exp_last(logic [CH_W-1:0] ch, logic [DW-1:0] dat);
      return {17'h0, ch, 2'b00, dat};
   endfunction : exp_last

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // Master holds the request until pready is seen at a rising edge
   task automatic apb(input logic w, input logic [AW-1:0] a, input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rd_chk(input logic [AW-1:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask : rd_chk

   task automatic conv();
      apb(1'b1, OFS_CTRL, 32'h1);
      repeat (30) @(posedge pclk);
   endtask : conv

   // Start, then a read whose access edge meets the end of conversion
   task automatic race_rd(input logic [AW-1:0] a, input logic [31:0] exp);
      apb(1'b1, OFS_CTRL, 32'h1);
      repeat (18) @(posedge pclk);
      rd_chk(a, exp);
      repeat (30) @(posedge pclk);
   endtask : race_rd

   task automatic end_sim();
      $display("checks=%0d errors=%0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : end_sim

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      sample = 10'h000;
      errors = 0;
      checks = 0;
      cyc = 0;
      void'($urandom(28));
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      // Reset values and an unmapped place
      rd_chk(OFS_CHSR, 32'h0);
      rd_chk(OFS_MODE, 32'h0);
      rd_chk(OFS_MASK, 32'h0);
      rd_chk(OFS_SR, 32'h0);
      rd_chk(OFS_EVT, 32'h0);
      rd_chk(8'hfc, 32'h0);
      chk({31'h0, err}, 32'h1);
      $display("test reset done");
      // Random channels: store, clear on read, overrun
      for (int i = 0; i < 4; i++) begin
         c = CH_W'($urandom_range(0, NCH - 1));
         d = DW'($urandom);
         sample <= d;
         apb(1'b1, OFS_CHEN, 32'h1 << c);
         rd_chk(OFS_CHSR, 32'h1 << c);
         conv();
         rd_chk(OFS_SR, exp_sr(8'h1 << c, 8'h0, 1'b1, 1'b0));
         rd_chk(OFS_LAST_RES, exp_last(c, d));
         rd_chk(OFS_SR, 32'h0);
         d = ~d;
         sample <= d;
         conv();
         rd_chk(OFS_CH_RES0 + AW'(4 * c), {22'h0, d});
         rd_chk(OFS_SR, 32'h0);
         conv();
         conv();
         rd_chk(OFS_SR, exp_sr(8'h1 << c, 8'h1 << c, 1'b1, 1'b1));
         rd_chk(OFS_SR, exp_sr(8'h1 << c, 8'h0, 1'b1, 1'b0));
         rd_chk(OFS_LAST_RES, exp_last(c, d));
         apb(1'b1, OFS_CHDIS, 32'h1 << c);
      end
      $display("test flags done");
      // Interrupt: raise, mask, clear
      apb(1'b1, OFS_CHEN, 32'h1);
      apb(1'b1, OFS_EVT, 32'h7);
      apb(1'b1, OFS_MASK, 32'h1 << EVT_EOC);
      repeat (2) @(posedge pclk);
      chk({31'h0, irq}, 32'h0);
      conv();
      chk({31'h0, irq}, 32'h1);
      rd_chk(OFS_EVT, 32'h3);
      apb(1'b1, OFS_MASK, 32'h0);
      repeat (2) @(posedge pclk);
      chk({31'h0, irq}, 32'h0);
      apb(1'b1, OFS_MASK, 32'h1 << EVT_EOC);
      apb(1'b1, OFS_EVT, 32'h1);
      repeat (2) @(posedge pclk);
      chk({31'h0, irq}, 32'h0);
      rd_chk(OFS_EVT, 32'h2);
      $display("test irq done");
      // Races on channel 0 with done and data-ready already set
      race_rd(OFS_SR, exp_sr(8'h01, 8'h0, 1'b1, 1'b0));
      rd_chk(OFS_SR, exp_sr(8'h01, 8'h01, 1'b1, 1'b0));
      race_rd(OFS_CH_RES0, {22'h0, d});
      rd_chk(OFS_SR, exp_sr(8'h01, 8'h01, 1'b0, 1'b1));
      $display("test race done");
      // Sleep asked while idle waits for a conversion
      apb(1'b1, OFS_MODE, 32'h1);
      rd_chk(OFS_MODE, 32'h1);
      repeat (30) @(posedge pclk);
      chk({31'h0, sleeping}, 32'h0);
      conv();
      chk({31'h0, sleeping}, 32'h1);
      $display("test sleep done");
      end_sim();
   end
endmodule : adc_status_flag_logic_tb
